// file: src/mpms_pkg.sv
// Shared constants and state types for the management serial link.
// Assumes both ends and the register slave run on the one interface clock.
package mpms_pkg;

    // ------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------
    localparam int          ADDR_W     = 8;           // Register address bits
    localparam int          DATA_W     = 8;           // Register data bits
    localparam logic        DIR_READ   = 1'b1;        // Direction bit for a read
    localparam logic        DIR_WRITE  = 1'b0;        // Direction bit for a write
    localparam logic [4:0]  RD_BITS    = 5'h0_00A;    // Dir, address, trailing zero
    localparam logic [4:0]  WR_BITS    = 5'h0_012;    // Dir, address, data, trailing zero
    localparam logic [3:0]  FRAME_TOP  = 4'h0_009;    // Index of start bit in reply frame
    localparam logic [4:0]  WAIT_MAX   = 5'h0_01F;    // Longest reply wait, cycles
    localparam logic [4:0]  WAIT_DEF   = 5'h0_004;    // Reply wait used by default
    localparam logic [5:0]  MAC_TMO    = 6'h0_021;    // Gap plus longest wait plus margin

    // ------------------------------------------------------------
    // Device register map
    // ------------------------------------------------------------
    localparam logic [7:0]  PM_ADDR    = 8'h0_006;    // power_mode_select
    localparam logic [7:0]  IDH_ADDR   = 8'h0_020;    // identity_high_octet
    localparam logic [7:0]  IDL_ADDR   = 8'h0_021;    // identity_low_octet
    localparam logic [7:0]  PM_READY   = 8'h0_000;    // Power mode value for READY
    localparam logic [7:0]  PM_RESET   = 8'h0_001;    // Power mode after reset
    localparam logic [15:0] ID_DEF     = 16'hA5C3;    // Identity, value is arbitrary

    // ------------------------------------------------------------
    // Controller register map (Wishbone byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0]  CMD_OFS    = 8'h0_000;    // Command: addr, wdata, read
    localparam logic [7:0]  STAT_OFS   = 8'h0_004;    // Status flags
    localparam logic [7:0]  RDAT_OFS   = 8'h0_008;    // Read data and wait seen
    localparam int          CMD_RD     = 16;          // Read select bit in command
    localparam int          ST_BUSY    = 0;           // Transaction running
    localparam int          ST_DONE    = 1;           // Sticky: transaction ended
    localparam int          ST_TOUT    = 2;           // Sticky: no reply start seen
    localparam int          ST_FERR    = 3;           // Sticky: trailing bit not zero

    // ------------------------------------------------------------
    // State machines
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        PS_IDLE  = 6'b00_0001,
        PS_DIR   = 6'b00_0010,
        PS_ADDR  = 6'b00_0100,
        PS_WDATA = 6'b00_1000,
        PS_TURN  = 6'b01_0000,
        PS_SEND  = 6'b10_0000
    } mpms_phy_st_t;

    typedef enum logic [4:0] {
        MS_IDLE  = 5'b0_0001,
        MS_SHIFT = 5'b0_0010,
        MS_WAIT  = 5'b0_0100,
        MS_RX    = 5'b0_1000,
        MS_TERM  = 5'b1_0000
    } mpms_mac_st_t;

endpackage : mpms_pkg

// file: src/mpms_link_if.sv
// Single management line shared by controller and device.
// Assumes an undriven line reads as zero, like a weak pull-down.
interface mpms_link_if (input wire logic clk);

    logic mac_sd_out;     // Controller drive value
    logic mac_sd_oe_n;    // Controller drives when low
    logic phy_sd_out;     // Device drive value
    logic phy_sd_oe_n;    // Device drives when low
    logic sd_line;        // Resolved line level

    // Wired level, zero when nobody drives
    assign sd_line = (!mac_sd_oe_n && mac_sd_out) || (!phy_sd_oe_n && phy_sd_out);

    modport mac (output mac_sd_out, output mac_sd_oe_n, input sd_line);
    modport phy (output phy_sd_out, output phy_sd_oe_n, input sd_line);

endinterface : mpms_link_if

// file: src/mpms_phy_end.sv
// Device end of the management serial link with its few registers.
// Assumes the line is sampled on clk, the same clock that launches it.
module mpms_phy_end
    import mpms_pkg::*;
#(
    parameter logic [4:0]  RESP_WAIT = WAIT_DEF,   // Low cycles before reply
    parameter logic [15:0] ID_VALUE  = ID_DEF      // Identity, value is arbitrary
)(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       srst,
    // Serial link
    mpms_link_if.phy        link,
    // Device side
    output logic [7:0]      power_mode,
    output logic            phy_ready
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Bit of the reply for cycles remaining r: zeros, start, data, zero
    function automatic logic resp_bit(input logic [5:0] r, input logic [7:0] d);
        logic [9:0] frame;
        frame = {1'b1, d, 1'b0};
        if (r > 6'(FRAME_TOP))
            return 1'b0;
        return frame[r[3:0]];
    endfunction : resp_bit

    mpms_phy_st_t st_q;         // Frame decoder state
    logic         rd_q;         // Direction bit captured
    logic [2:0]   cnt_q;        // Bit counter in a field
    logic [7:0]   addr_q;       // Register address
    logic [7:0]   wdat_q;       // Write data shift
    logic [7:0]   txd_q;        // Reply data held
    logic [5:0]   rem_q;        // Reply cycles left
    logic         out_q;        // Line value
    logic         oe_n_q;       // Line enable, low drives
    logic [7:0]   pm_q;         // power_mode_select
    logic         rdy_q;        // READY state
    logic         wr_ev;        // Write completes this edge
    logic [7:0]   rd_val;       // Read mux
    logic [7:0]   wr_val;       // Value being written

    assign wr_ev  = (st_q == PS_WDATA) && (cnt_q == 3'h0_000);
    assign wr_val = {wdat_q[6:0], link.sd_line};

    // Register read decode, unmapped reads as zero
    always_comb
    begin
        case (addr_q)
            PM_ADDR:  rd_val = pm_q;
            IDH_ADDR: rd_val = ID_VALUE[15:8];
            IDL_ADDR: rd_val = ID_VALUE[7:0];
            default:  rd_val = 8'h0_000;
        endcase
    end

    // ------------------------------------------------------------
    // Frame decoder and reply driver
    // ------------------------------------------------------------
    // Line bits sampled on the rising edge, MSB first
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            st_q   <= PS_IDLE;
            rd_q   <= 1'b0;
            cnt_q  <= 3'h0_000;
            addr_q <= 8'h0_000;
            wdat_q <= 8'h0_000;
            txd_q  <= 8'h0_000;
            rem_q  <= 6'h0_000;
            out_q  <= 1'b0;
            oe_n_q <= 1'b1;
        end
        else
        begin
            case (st_q)
                PS_IDLE:
                begin
                    // Any high is a start bit, even right after a reply
                    if (link.sd_line)
                        st_q <= PS_DIR;
                end
                PS_DIR:
                begin
                    rd_q  <= link.sd_line;
                    cnt_q <= 3'h0_007;
                    st_q  <= PS_ADDR;
                end
                PS_ADDR:
                begin
                    addr_q <= {addr_q[6:0], link.sd_line};
                    cnt_q  <= cnt_q - 3'h0_001;
                    if (cnt_q == 3'h0_000)
                    begin
                        // Read: skip trailing zero and the released cycle
                        cnt_q <= (rd_q == DIR_READ) ? 3'h0_001 : 3'h0_007;
                        st_q  <= (rd_q == DIR_READ) ? PS_TURN : PS_WDATA;
                    end
                end
                PS_WDATA:
                begin
                    wdat_q <= wr_val;
                    cnt_q  <= cnt_q - 3'h0_001;
                    if (cnt_q == 3'h0_000)
                        st_q <= PS_IDLE;
                end
                PS_TURN:
                begin
                    cnt_q <= cnt_q - 3'h0_001;
                    // First clock after release: start driving
                    if (cnt_q == 3'h0_000)
                    begin
                        txd_q  <= rd_val;
                        rem_q  <= 6'(RESP_WAIT) + 6'(FRAME_TOP);
                        out_q  <= resp_bit(6'(RESP_WAIT) + 6'(FRAME_TOP), rd_val);
                        oe_n_q <= 1'b0;
                        st_q   <= PS_SEND;
                    end
                end
                PS_SEND:
                begin
                    if (rem_q == 6'h0_000)
                    begin
                        // Terminating zero done, hand line back
                        out_q  <= 1'b0;
                        oe_n_q <= 1'b1;
                        st_q   <= PS_IDLE;
                    end
                    else
                    begin
                        rem_q <= rem_q - 6'h0_001;
                        out_q <= resp_bit(rem_q - 6'h0_001, txd_q);
                    end
                end
                default:
                    st_q <= PS_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Register store
    // ------------------------------------------------------------
    // Only power mode is writable; identity octets ignore writes
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pm_q  <= PM_RESET;
            rdy_q <= 1'b0;
        end
        else if (wr_ev && (addr_q == PM_ADDR))
        begin
            pm_q  <= wr_val;
            rdy_q <= (wr_val == PM_READY);
        end
    end

    assign link.phy_sd_out  = out_q;
    assign link.phy_sd_oe_n = oe_n_q;
    assign power_mode       = pm_q;
    assign phy_ready        = rdy_q;

endmodule : mpms_phy_end

// file: src/mpms_mac_end.sv
// Controller end of the management serial link, run from Wishbone.
// Assumes a classic Wishbone master on clk and the device on the link.
module mpms_mac_end
    import mpms_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic             wb_ack_o,
    output logic [31:0]      wb_dat_o,
    // Serial link
    mpms_link_if.mac         link
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    mpms_mac_st_t st_q;           // Serial state
    logic         ack_q;          // Bus acknowledge
    logic [31:0]  dat_q;          // Bus read data
    logic [16:0]  cmd_q;          // Read bit, wdata, address
    logic [17:0]  tx_q;           // Bits after the start bit
    logic [4:0]   cnt_q;          // Bits left
    logic [7:0]   rx_q;           // Reply shift
    logic [5:0]   wcnt_q;         // Low cycles seen in wait
    logic [7:0]   rdat_q;         // Last read data
    logic [5:0]   wseen_q;        // Wait length of last read
    logic         out_q;          // Line value
    logic         oe_n_q;         // Line enable, low drives
    logic         done_q;         // Sticky done
    logic         tout_q;         // Sticky timeout
    logic         ferr_q;         // Sticky framing error
    logic         wb_take;        // Write takes effect now
    logic         go;             // Start a transaction
    logic         clr;            // Status clear write
    logic         ev_wr_end;      // Write frame finished
    logic         ev_tout;        // No reply start in time
    logic         ev_term;        // Reply trailing bit sampled
    logic         busy;           // Not idle

    assign busy      = (st_q != MS_IDLE);
    assign wb_take   = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
    assign go        = wb_take && (wb_adr_i == CMD_OFS) && !busy;
    assign clr       = wb_take && (wb_adr_i == STAT_OFS) && wb_sel_i[0];
    assign ev_wr_end = (st_q == MS_SHIFT) && (cnt_q == 5'h0_000) && !cmd_q[CMD_RD];
    assign ev_tout   = (st_q == MS_WAIT) && !link.sd_line && (wcnt_q == MAC_TMO);
    assign ev_term   = (st_q == MS_TERM);

    // ------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------
    // Ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk)
    begin
        if (srst)
            ack_q <= 1'b0;
        else
            ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
    end

    // Read data captured with the ack; unmapped reads zero
    always_ff @(posedge clk)
    begin
        if (srst)
            dat_q <= 32'h0000_0000;
        else if (wb_cyc_i && wb_stb_i && !ack_q)
        begin
            case (wb_adr_i)
                CMD_OFS:  dat_q <= {15'h0_000, cmd_q};
                STAT_OFS: dat_q <= {28'h000_0000, ferr_q, tout_q, done_q, busy};
                RDAT_OFS: dat_q <= {18'h0_0000, wseen_q, rdat_q};
                default:  dat_q <= 32'h0000_0000;
            endcase
        end
    end

    // Command register, byte lanes 0 and 1 honoured, frozen while busy
    always_ff @(posedge clk)
    begin
        if (srst)
            cmd_q <= 17'h0_0000;
        else if (go)
        begin
            if (wb_sel_i[0])
                cmd_q[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1])
                cmd_q[15:8] <= wb_dat_i[15:8];
            // Direction always latched, since the frame end decision uses it
            cmd_q[CMD_RD] <= wb_dat_i[CMD_RD];
        end
    end

    // ------------------------------------------------------------
    // Serial engine
    // ------------------------------------------------------------
    // Uses wb_dat_i lanes 0 to 2, whatever wb_sel_i, so a one-word command starts at once
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            st_q   <= MS_IDLE;
            tx_q   <= 18'h0_0000;
            cnt_q  <= 5'h0_000;
            rx_q   <= 8'h0_000;
            wcnt_q <= 6'h0_000;
            out_q  <= 1'b0;
            oe_n_q <= 1'b0;
        end
        else
        begin
            case (st_q)
                MS_IDLE:
                begin
                    out_q  <= 1'b0;
                    oe_n_q <= 1'b0;
                    if (go)
                    begin
                        out_q <= 1'b1;
                        if (wb_dat_i[CMD_RD])
                        begin
                            tx_q  <= {DIR_READ, wb_dat_i[7:0], 1'b0, 8'h0_000};
                            cnt_q <= RD_BITS;
                        end
                        else
                        begin
                            tx_q  <= {DIR_WRITE, wb_dat_i[7:0], wb_dat_i[15:8], 1'b0};
                            cnt_q <= WR_BITS;
                        end
                        st_q <= MS_SHIFT;
                    end
                end
                MS_SHIFT:
                begin
                    if (cnt_q == 5'h0_000)
                    begin
                        out_q <= 1'b0;
                        if (cmd_q[CMD_RD])
                        begin
                            // Trailing zero sent, let the device answer
                            oe_n_q <= 1'b1;
                            wcnt_q <= 6'h0_000;
                            st_q   <= MS_WAIT;
                        end
                        else
                            st_q <= MS_IDLE;
                    end
                    else
                    begin
                        // One bit per clock, address and data MSB first
                        out_q <= tx_q[17];
                        tx_q  <= {tx_q[16:0], 1'b0};
                        cnt_q <= cnt_q - 5'h0_001;
                    end
                end
                MS_WAIT:
                begin
                    if (link.sd_line)
                    begin
                        // Start of reply data
                        cnt_q <= 5'h0_008;
                        st_q  <= MS_RX;
                    end
                    else if (ev_tout)
                    begin
                        // Device silent: take the line back low
                        oe_n_q <= 1'b0;
                        st_q   <= MS_IDLE;
                    end
                    else
                        wcnt_q <= wcnt_q + 6'h0_001;
                end
                MS_RX:
                begin
                    rx_q  <= {rx_q[6:0], link.sd_line};
                    cnt_q <= cnt_q - 5'h0_001;
                    if (cnt_q == 5'h0_001)
                        st_q <= MS_TERM;
                end
                MS_TERM:
                begin
                    // Device's zero sampled, it releases now; drive low
                    oe_n_q <= 1'b0;
                    out_q  <= 1'b0;
                    st_q   <= MS_IDLE;
                end
                default:
                    st_q <= MS_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Results and sticky status
    // ------------------------------------------------------------
    // Read data kept until the next answered read ends; wait seen updates at its start bit
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            rdat_q  <= 8'h0_000;
            wseen_q <= 6'h0_000;
        end
        else
        begin
            if (ev_term)
                rdat_q <= rx_q;
            if ((st_q == MS_WAIT) && link.sd_line)
                wseen_q <= wcnt_q;
        end
    end

    // Set beats clear in the same cycle so no event is lost
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            done_q <= 1'b0;
            tout_q <= 1'b0;
            ferr_q <= 1'b0;
        end
        else
        begin
            if (ev_wr_end || ev_term || ev_tout)
                done_q <= 1'b1;
            else if (clr && wb_dat_i[ST_DONE])
                done_q <= 1'b0;
            if (ev_tout)
                tout_q <= 1'b1;
            else if (clr && wb_dat_i[ST_TOUT])
                tout_q <= 1'b0;
            if (ev_term && link.sd_line)
                ferr_q <= 1'b1;
            else if (clr && wb_dat_i[ST_FERR])
                ferr_q <= 1'b0;
        end
    end

    assign wb_ack_o         = ack_q;
    assign wb_dat_o         = dat_q;
    assign link.mac_sd_out  = out_q;
    assign link.mac_sd_oe_n = oe_n_q;

endmodule : mpms_mac_end

// file: sim/mpms_chk.sv
// Checker for the management line between the two ends.
// Assumes it sits beside the link interface in tb, on the one clock.
module mpms_chk
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // Line drivers of both ends
    input  wire logic mac_sd_out,
    input  wire logic mac_sd_oe_n,
    input  wire logic phy_sd_out,
    input  wire logic phy_sd_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    logic [4:0] pos_q;     // Place in a controller frame, 0 when idle
    logic       rd_q;      // Frame is a read
    logic       seen_q;    // Reply start bit already driven
    logic [5:0] wcnt_q;    // Low reply cycles before start bit

    // --------------------------------
    // Frame tracking
    // --------------------------------
    // Wraps after a write's trailing zero or a read's released cycle, so a reply never looks like a start
    always_ff @(posedge clk)
    begin
        if (srst || pos_q == 5'h12 || (rd_q && pos_q == 5'h0B))
            pos_q <= 5'h0;
        else if (pos_q != 5'h0 || (!mac_sd_oe_n && mac_sd_out))
            pos_q <= pos_q + 5'h1;
    end

    // Direction bit follows the start bit
    always_ff @(posedge clk)
    begin
        if (srst)
            rd_q <= 1'b0;
        else if (pos_q == 5'h1)
            rd_q <= mac_sd_out;
    end

    // Reply wait count, cleared whenever the device lets go
    always_ff @(posedge clk)
    begin
        if (srst || phy_sd_oe_n)
        begin
            seen_q <= 1'b0;
            wcnt_q <= 6'h0;
        end
        else if (phy_sd_out)
            seen_q <= 1'b1;
        else if (!seen_q)
            wcnt_q <= wcnt_q + 6'h1;
    end

    // --------------------------------
    // Rules on the wire
    // --------------------------------
    sequence rd_tail;
        (!mac_sd_out && !mac_sd_oe_n) ##1 mac_sd_oe_n;
    endsequence
    sequence reply_end;
        (!phy_sd_out && !phy_sd_oe_n) ##1 (phy_sd_oe_n && !mac_sd_oe_n && !mac_sd_out);
    endsequence

    no_clash_a: assert property (mac_sd_oe_n || phy_sd_oe_n) else $error("line driven by both ends");
    phy_quiet_a: assert property (pos_q != 5'h0 |-> phy_sd_oe_n) else $error("device drove in frame");
    rd_frame_a: assert property (pos_q == 5'h1 && mac_sd_out |-> ##9 rd_tail) else $error("bad read tail");
    wr_frame_a: assert property (pos_q == 5'h1 && !mac_sd_out |-> !mac_sd_oe_n throughout ##17 (!mac_sd_out ##1 !mac_sd_out))
        else $error("bad write tail");
    turn_gap_a: assert property ($rose(mac_sd_oe_n) |-> phy_sd_oe_n ##1 !phy_sd_oe_n) else $error("bad turn gap");
    wait_max_a: assert property (!phy_sd_oe_n && !seen_q |-> wcnt_q <= 6'h1F) else $error("reply wait too long");
    reply_end_a: assert property (!phy_sd_oe_n && phy_sd_out && !seen_q |-> ##9 reply_end)
        else $error("bad reply frame");
    release_pos_a: assert property ($rose(mac_sd_oe_n) |-> pos_q == 5'h0B && rd_q) else $error("early release");
endmodule : mpms_chk

// file: sim/tb.sv
// Bench joining controller and device ends over the link.
// Assumes the package, link interface and both ends compile first.
module tb
    import mpms_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [4:0]  W   = 5'h2;       // Reply wait under test
    localparam logic [15:0] IDV = 16'h3C5A;   // Identity, value is arbitrary

    logic        clk = 1'b0;      // 25 MHz clock
    logic        srst = 1'b1;     // Synchronous reset
    logic        wb_cyc = 1'b0;   // Bus cycle
    logic        wb_stb = 1'b0;   // Bus strobe
    logic        wb_we = 1'b0;    // Bus direction
    logic [3:0]  wb_sel = 4'h0;   // Bus byte lanes
    logic [7:0]  wb_adr = 8'h0;   // Bus address
    logic [31:0] wb_dat = 32'h0;  // Bus write data
    logic        wb_ack;          // Bus answer
    logic [31:0] wb_q;            // Bus read data
    logic [7:0]  pm_o;            // Device power mode
    logic        rdy_o;           // Device ready
    logic [7:0]  pm_exp;          // Expected power mode
    logic [7:0]  a;               // Device address
    logic [31:0] rv;              // Last bus read
    int          miscompares = 0;
    int          check_count = 0;

    always #20 clk = ~clk;

    mpms_link_if u_mpms_link_if (.clk(clk));
    mpms_mac_end u_mpms_mac_end (.clk(clk), .srst(srst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_ack_o(wb_ack), .wb_dat_o(wb_q),
        .link(u_mpms_link_if));
    mpms_phy_end #(.RESP_WAIT(W), .ID_VALUE(IDV)) u_mpms_phy_end (.clk(clk), .srst(srst),
        .link(u_mpms_link_if), .power_mode(pm_o), .phy_ready(rdy_o));
    mpms_chk u_mpms_chk (.clk(clk), .srst(srst), .mac_sd_out(u_mpms_link_if.mac_sd_out),
        .mac_sd_oe_n(u_mpms_link_if.mac_sd_oe_n), .phy_sd_out(u_mpms_link_if.phy_sd_out),
        .phy_sd_oe_n(u_mpms_link_if.phy_sd_oe_n));

    // Expected read word: register octet plus wait seen
    function automatic logic [31:0] exp_rd(input logic [7:0] ad, input logic [7:0] pm);
        logic [7:0] v;
        v = (ad == PM_ADDR) ? pm : (ad == IDH_ADDR) ? IDV[15:8] : (ad == IDL_ADDR) ? IDV[7:0] : 8'h0;
        return {18'h0, 6'(W) + 6'h1, v};
    endfunction : exp_rd

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // Classic single cycle, held until ack is sampled
    task automatic wb(input logic we, input logic [7:0] ad, input logic [31:0] d, output logic [31:0] q);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_sel <= 4'hF;
        wb_adr <= ad;
        wb_dat <= d;
        @(posedge clk);
        while (wb_ack !== 1'b1)
            @(posedge clk);
        q = wb_q;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk);
    endtask : wb

    // One device access, polled to done; the watchdog cuts a hang
    task automatic dev(input logic rd, input logic [7:0] ad, input logic [7:0] d, output logic [31:0] q);
        wb(1'b1, CMD_OFS, {15'h0, rd, d, ad}, q);
        q = 32'h0;
        while (q[ST_DONE] !== 1'b1)
            wb(1'b0, STAT_OFS, 32'h0, q);
        chk("status", q, 32'h2);
        wb(1'b1, STAT_OFS, 32'hE, q);
        if (rd)
            wb(1'b0, RDAT_OFS, 32'h0, q);
    endtask : dev

    task automatic print_verdict();
        if (miscompares == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict

    // Main sequence: writes and reads alternate, each polled to done before the next
    initial
    begin
        void'($urandom(32'hb98d));
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        pm_exp = PM_RESET;
        chk("idle_line", {31'h0, u_mpms_link_if.sd_line}, 32'h0);
        wb(1'b0, 8'h0C, 32'h0, rv);
        chk("unmapped", rv, 32'h0);
        for (int i = 0; i < 12; i++)
        begin
            a = (i % 4 == 0) ? PM_ADDR : (i % 4 == 1) ? IDH_ADDR : (i % 4 == 2) ? IDL_ADDR : 8'($urandom);
            dev(1'b1, a, 8'($urandom), rv);
            chk("rdata", rv, exp_rd(a, pm_exp));
            a = (i % 3 == 2) ? IDH_ADDR : PM_ADDR;
            rv = (i == 4) ? 32'h0 : $urandom;
            if (a == PM_ADDR)
                pm_exp = rv[7:0];
            dev(1'b0, a, rv[7:0], rv);
            chk("power_mode", {24'h0, pm_o}, {24'h0, pm_exp});
            chk("ready", {31'h0, rdy_o}, {31'h0, pm_exp == PM_READY});
        end
        print_verdict();
    end

    // Watchdog on the whole run
    initial
    begin
        #800000;
        miscompares++;
        print_verdict();
    end
endmodule : tb
